// ===== wdt_consts.vh
// constants of the timeout watchdog: offsets, fields, reset values, timing
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH
// register byte offsets on the avalon slave
`define OFS_CTRL_ONE 4'h0
`define OFS_CTRL_TWO 4'h1
`define OFS_STATUS 4'h2
`define OFS_IRQ_STAT 4'h3
`define OFS_IRQ_MASK 4'h4
// general_control_one fields
`define C1_TRIG 0
`define C1_PERIOD 1
`define C1_UNLOCK 2
// general_control_two fields
`define C2_DISABLE 0
// general_status_reg fields
`define ST_FAILSAFE 0
`define ST_POS_LO 1
`define ST_POS_HI 2
`define ST_ENABLED 3
// interrupt status / mask fields
`define IRQ_TIMEOUT 0
`define IRQ_BADTRIG 1
`define IRQ_FAILSAFE_EXIT 2
`define IRQ_WIDTH 3
// reset values
`define CTRL_ONE_RST 8'h00
`define CTRL_TWO_RST 8'h00
`define IRQ_MASK_RST 3'h0
// timing: periods in ms, clock in kHz
`define CLK_KHZ 40000
`define PERIOD_SHORT_MS 50
`define PERIOD_LONG_MS 200
`define PERIOD_SHORT_CYC (`PERIOD_SHORT_MS * `CLK_KHZ)
`define PERIOD_LONG_CYC (`PERIOD_LONG_MS * `CLK_KHZ)
`endif

// ===== wdt_timer.v
// watchdog period timer with quarter-position report
`include "wdt_consts.vh"
module wdt_timer #(
  parameter SHORT_CYC = `PERIOD_SHORT_CYC,
  parameter LONG_CYC = `PERIOD_LONG_CYC
) (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // control
  input wire run_in,
  input wire restart_in,
  input wire long_in,
  // status
  output wire expire_out,
  output reg [1:0] position_out
);
  reg [31:0] count_q;
  wire [31:0] limit;
  wire [31:0] quarter;
  assign limit = long_in ? LONG_CYC : SHORT_CYC; // [RULE1]
  assign quarter = {2'b00, limit[31:2]};
  assign expire_out = run_in && (count_q >= limit - 32'h1); // [RULE4]
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      count_q <= 32'h0;
      position_out <= 2'h0;
    end
    else
    begin
      if (restart_in || !run_in || expire_out)
        count_q <= 32'h0; // [RULE3] [RULE17]
      else
        count_q <= count_q + 32'h1;
      if (restart_in || !run_in)
        position_out <= 2'h0;
      else if (expire_out)
      begin
        // short period keeps last quarter code across a timeout
        if (long_in)
          position_out <= 2'h0;
      end // [RULE11]
      else if (count_q >= quarter + quarter + quarter)
        position_out <= 2'h3; // [RULE10]
      else if (count_q >= quarter + quarter)
        position_out <= 2'h2;
      else if (count_q >= quarter)
        position_out <= 2'h1;
      else
        position_out <= 2'h0;
    end
  end
endmodule

// ===== wdt_failsafe.v
// timeout watchdog with fail-safe latch, exit sequence and avalon registers
`include "wdt_consts.vh"
//
// Contract
// RULE1 - period_select picks one of two periods
// RULE2 - trigger starts 0, controller writes inverse
// RULE3 - valid trigger restarts counter at once
// RULE4 - expiry without valid trigger is failure
// RULE5 - rewriting same trigger value is failure
// RULE6 - failure latches flag, forces controls default
// RULE7 - exit: clear status, trigger 1, trigger 0
// RULE8 - exit frames strictly consecutive, no others
// RULE9 - stray frame restarts exit sequence
// RULE10 - two-bit field reports timer quarter
// RULE11 - short period keeps position after timeout; code holds it for one clock, then the position restarts from 0 with the count
// RULE12 - watchdog enabled after reset
// RULE13 - disable: unlock frame then disable frame
// RULE14 - unlock clears after following frame ends; code clears it at the next access or any frame_end, its own included
// RULE15 - clearing disable re-enables at once
// RULE16 - reset holds block, drivers off
// RULE17 - disabled watchdog never times out
module wdt_failsafe #(
  parameter SHORT_CYC = `PERIOD_SHORT_CYC,
  parameter LONG_CYC = `PERIOD_LONG_CYC
) (
  // clock and reset (reset is the logic-supply undervoltage)
  input wire clk_in,
  input wire rst_in,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // serial link frame marker from the interface, async to clk_in
  input wire frame_sel_n_in,
  // gate driver enable and interrupt
  output reg drivers_on_out,
  output wire irq_out
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_CLEARED = 4'b0010;
  localparam ST_TRIG_HI = 4'b0100;
  localparam ST_NORMAL = 4'b1000;

  reg [7:0] ctrl_one_q;
  reg [7:0] ctrl_two_q;
  reg failsafe_q;
  reg [3:0] exit_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  reg [2:0] irq_set;
  reg unlock_age_q;
  reg ack_q;
  reg sel_meta_q;
  reg sel_sync_q;
  reg sel_prev_q;
  wire frame_end;
  wire acc;
  wire wr;
  wire rd;
  wire wr_c1;
  wire wr_c2;
  wire wr_stat;
  wire trigger_toggle;
  wire period_select;
  wire timeout_disable;
  wire run;
  wire expire;
  wire [1:0] timer_position;
  wire new_trig;
  wire good_trig;
  wire bad_trig;
  wire fail;
  wire other_frame;
  wire [7:0] general_status_reg;

  // one wait state per access: accept on second cycle
  assign acc = (avs_read || avs_write) && !ack_q;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr = avs_write && ack_q;
  assign rd = avs_read && ack_q;
  assign wr_c1 = wr && (avs_address == `OFS_CTRL_ONE);
  assign wr_c2 = wr && (avs_address == `OFS_CTRL_TWO);
  assign wr_stat = wr && (avs_address == `OFS_STATUS);

  // each completed access stands for one serial frame
  assign trigger_toggle = ctrl_one_q[`C1_TRIG];
  assign period_select = ctrl_one_q[`C1_PERIOD];
  assign timeout_disable = ctrl_two_q[`C2_DISABLE];
  assign new_trig = avs_writedata[`C1_TRIG];
  assign good_trig = wr_c1 && (new_trig != trigger_toggle); // [RULE2]
  assign bad_trig = wr_c1 && (new_trig == trigger_toggle) && !failsafe_q; // [RULE5]
  assign run = !timeout_disable; // [RULE12] [RULE17]
  assign fail = run && !failsafe_q && (expire || bad_trig); // [RULE4] [RULE5]
  assign general_status_reg = {4'h0, run, timer_position, failsafe_q};

  wdt_timer #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in(run),
    .restart_in(good_trig && run), // [RULE3]
    .long_in(period_select),
    .expire_out(expire),
    .position_out(timer_position)
  );

  // frame marker passes two flip-flops; rising edge ends a frame
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sel_meta_q <= 1'b1;
      sel_sync_q <= 1'b1;
      sel_prev_q <= 1'b1;
    end
    else
    begin
      sel_meta_q <= frame_sel_n_in;
      sel_sync_q <= sel_meta_q;
      sel_prev_q <= sel_sync_q;
    end
  end
  assign frame_end = sel_sync_q && !sel_prev_q;

  // an access in fail-safe that is not the expected step breaks the sequence
  assign other_frame = (wr || rd) && !(wr_stat && exit_q == ST_IDLE)
    && !(wr_c1 && exit_q == ST_CLEARED && new_trig)
    && !(wr_c1 && exit_q == ST_TRIG_HI && !new_trig);

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ack_q <= 1'b0;
      ctrl_one_q <= `CTRL_ONE_RST; // [RULE2] [RULE16]
      ctrl_two_q <= `CTRL_TWO_RST;
      failsafe_q <= 1'b0;
      exit_q <= ST_NORMAL;
      unlock_age_q <= 1'b0;
      drivers_on_out <= 1'b0; // [RULE16]
    end
    else
    begin
      ack_q <= acc;
      drivers_on_out <= !failsafe_q && !fail;
      if (fail)
      begin
        failsafe_q <= 1'b1; // [RULE6]
        ctrl_one_q <= `CTRL_ONE_RST; // [RULE6]
        ctrl_two_q <= `CTRL_TWO_RST;
        exit_q <= ST_IDLE;
        unlock_age_q <= 1'b0;
      end
      else if (failsafe_q)
      begin
        // exit steps; controls stay frozen except the trigger bit
        case (exit_q)
          ST_IDLE:
            if (wr_stat)
              exit_q <= ST_CLEARED; // [RULE7]
          ST_CLEARED:
            if (other_frame)
              exit_q <= ST_IDLE; // [RULE9] [RULE8]
            else if (wr_c1)
            begin
              exit_q <= ST_TRIG_HI;
              ctrl_one_q[`C1_TRIG] <= 1'b1;
            end
            else if (expire)
              exit_q <= ST_IDLE;
          ST_TRIG_HI:
            if (other_frame)
            begin
              exit_q <= ST_IDLE; // [RULE9]
              ctrl_one_q[`C1_TRIG] <= 1'b0;
            end
            else if (wr_c1)
            begin
              exit_q <= ST_NORMAL; // [RULE7]
              failsafe_q <= 1'b0;
              ctrl_one_q[`C1_TRIG] <= 1'b0;
            end
            else if (expire)
            begin
              exit_q <= ST_IDLE;
              ctrl_one_q[`C1_TRIG] <= 1'b0;
            end
          default:
            exit_q <= ST_IDLE;
        endcase
      end
      else
      begin
        if (wr_c1)
        begin
          ctrl_one_q <= avs_writedata[7:0];
          unlock_age_q <= avs_writedata[`C1_UNLOCK];
        end
        else if (wr || rd || frame_end)
        begin
          // next access or any frame end, the unlock frame's own included: unlock drops back
          ctrl_one_q[`C1_UNLOCK] <= 1'b0; // [RULE14]
          unlock_age_q <= 1'b0;
        end
        if (wr_c2)
        begin
          if (!avs_writedata[`C2_DISABLE])
            ctrl_two_q[`C2_DISABLE] <= 1'b0; // [RULE15]
          else if (ctrl_one_q[`C1_UNLOCK] && unlock_age_q)
            ctrl_two_q[`C2_DISABLE] <= 1'b1; // [RULE13]
          ctrl_two_q[7:1] <= avs_writedata[7:1];
        end
      end
    end
  end

  // interrupts: sticky, write one to clear, set wins over clear
  always @*
  begin
    irq_set = 3'h0;
    irq_set[`IRQ_TIMEOUT] = fail && expire;
    irq_set[`IRQ_BADTRIG] = fail && bad_trig;
    irq_set[`IRQ_FAILSAFE_EXIT] = failsafe_q && wr_c1 && exit_q == ST_TRIG_HI && !other_frame;
  end
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= `IRQ_MASK_RST;
    end
    else
    begin
      if (wr && avs_address == `OFS_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~avs_writedata[2:0]) | irq_set;
      else
        irq_stat_q <= irq_stat_q | irq_set;
      if (wr && avs_address == `OFS_IRQ_MASK)
        irq_mask_q <= avs_writedata[2:0];
    end
  end
  assign irq_out = |(irq_stat_q & irq_mask_q);

  // read data registered on the edge that ends the wait state, one edge before acceptance
  always @(posedge clk_in)
  begin
    if (rst_in)
      avs_readdata <= 32'h0;
    else if (acc)
    begin
      case (avs_address)
        `OFS_CTRL_ONE: avs_readdata <= {24'h0, ctrl_one_q};
        `OFS_CTRL_TWO: avs_readdata <= {24'h0, ctrl_two_q};
        `OFS_STATUS: avs_readdata <= {24'h0, general_status_reg};
        `OFS_IRQ_STAT: avs_readdata <= {29'h0, irq_stat_q};
        `OFS_IRQ_MASK: avs_readdata <= {29'h0, irq_mask_q};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end
endmodule

// ===== frame_marker.sv
// far-side model: one low pulse on the frame select line for each completed access
module frame_marker (
  input wire logic clk_in,
  input wire logic done_in,
  output logic frame_sel_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    frame_sel_n_out = 1'b1;
    forever
    begin
      @(negedge clk_in iff done_in); // one access is one frame
      #5 frame_sel_n_out = 1'b0;
      #60 frame_sel_n_out = 1'b1;
    end
  end
endmodule

// ===== wdt_failsafe_chk.sv
// port checker for the timeout watchdog
`include "wdt_consts.vh"
module wdt_failsafe_chk #(
  parameter SHORT_CYC = 400
) (
  input wire clk_in,
  input wire rst_in,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire frame_sel_n_in,
  input wire drivers_on_out,
  input wire irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  int since_q;
  wire done = (avs_read | avs_write) & ~avs_waitrequest;
  wire wr_done = done & avs_write;
  // cycles since the last completed trigger register write
  always @(posedge clk_in)
    since_q <= (rst_in || (wr_done && avs_address == `OFS_CTRL_ONE)) ? 0 : since_q + 1;
  chk_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest) else $error("no wait cycle");
  chk_wait_one: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  chk_drv_release: assert property ($fell(rst_in) |-> ##[0:1] drivers_on_out) else $error("drivers stay off");
  chk_irq_reset: assert property ($fell(rst_in) |-> !irq_out) else $error("irq after reset");
  chk_fs_latch: assert property (!drivers_on_out && !$past(rst_in) && !wr_done && !$past(wr_done)
    |=> !drivers_on_out) else $error("fail-safe left alone");
  chk_fail_cause: assert property ($fell(drivers_on_out) |-> $past(wr_done) || $past(wr_done, 2)
    || since_q >= SHORT_CYC - 4) else $error("failure without cause");
  chk_unmapped_zero: assert property (done && avs_read && avs_address > `OFS_IRQ_MASK |-> avs_readdata == 32'h0)
    else $error("unmapped read");
  chk_upper_zero: assert property (done && avs_read |-> avs_readdata[31:8] == 24'h0) else $error("upper bits");
  chk_status_flag: assert property (done && avs_read && avs_address == `OFS_STATUS
    |-> avs_readdata[`ST_FAILSAFE] != drivers_on_out) else $error("flag and drivers disagree");
endmodule
bind wdt_failsafe wdt_failsafe_chk #(.SHORT_CYC(SHORT_CYC)) chk_i (.*);

// ===== timeout_watchdog_failsafe_tb.sv
// testbench of the timeout watchdog with fail-safe
`include "wdt_consts.vh"
module timeout_watchdog_failsafe_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, rst_in = 1, avs_read = 0, avs_write = 0, frame_sel_n_in, t;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
  logic avs_waitrequest, drivers_on_out, irq_out;
  int error_cnt = 0, checks = 0;
  wdt_failsafe #(.SHORT_CYC(400), .LONG_CYC(1600)) uut (.*);
  frame_marker fm (.clk_in(clk_in), .done_in((avs_read | avs_write) & ~avs_waitrequest),
    .frame_sel_n_out(frame_sel_n_in));
  initial forever #12.5 clk_in = ~clk_in;
  // request held until the rising edge that samples waitrequest low; only the watchdog ends a hang
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do
      @(posedge clk_in);
    while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk_in);
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tog(input logic [31:0] x);
    t = ~t;
    acc(1, `OFS_CTRL_ONE, x | t | ($urandom & 32'hffffff00));
  endtask
  task automatic stat(input logic [31:0] m, input logic [31:0] e);
    acc(0, `OFS_STATUS, 0);
    ck(rdat & m, e);
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #1000000;
    error_cnt++;
    give_verdict;
  end
  initial
  begin
    void'($urandom(78));
    t = 0;
    wt(8);
    rst_in <= 0;
    acc(0, `OFS_CTRL_ONE, 0);
    ck(rdat, 0);
    stat(9, 8);
    acc(1, `OFS_IRQ_MASK, 7);
    repeat (4)
    begin
      wt($urandom_range(300));
      tog(0);
    end
    stat(1, 0);
    wt(250);
    stat(6, 4);
    tog(2);
    wt(1000);
    stat(7, 4);
    acc(1, `OFS_CTRL_ONE, 2 | t);
    stat(1, 1);
    ck(drivers_on_out, 0);
    ck(irq_out, 1);
    acc(0, `OFS_IRQ_STAT, 0);
    ck(rdat, 2);
    acc(1, `OFS_IRQ_STAT, 7);
    wt(1);
    ck(irq_out, 0);
    acc(0, `OFS_CTRL_ONE, 0);
    ck(rdat, 0);
    for (int i = 0; i < 2; i++)
    begin
      acc(1, `OFS_STATUS, 0);
      if (i == 0)
        acc(0, `OFS_STATUS, 0);
      acc(1, `OFS_CTRL_ONE, 1);
      acc(1, `OFS_CTRL_ONE, 0);
      stat(1, 32'(i == 0));
    end
    ck(drivers_on_out, 1);
    acc(0, `OFS_IRQ_STAT, 0);
    ck(rdat & 4, 4);
    acc(1, `OFS_IRQ_STAT, 7);
    t = 0;
    wt(450);
    stat(1, 1);
    acc(0, `OFS_IRQ_STAT, 0);
    ck(rdat & 1, 1);
    rst_in <= 1;
    wt(3);
    rst_in <= 0;
    wt(1);
    stat(1, 0);
    ck(drivers_on_out, 1);
    t = 0;
    tog(4);
    acc(1, `OFS_CTRL_TWO, 1);
    wt(500);
    stat(9, 0);
    acc(1, `OFS_CTRL_TWO, 0);
    stat(8, 8);
    tog(4);
    acc(0, `OFS_CTRL_ONE, 0);
    acc(1, `OFS_CTRL_TWO, 1);
    stat(9, 8);
    acc(0, 4'h7, 0);
    ck(rdat, 0);
    give_verdict;
  end
endmodule
